/* hdl/lvpc_pkg.sv */
/*
 * Package for the panel port control block: register map, field layout,
 * lane codes and carrier structs.
 * Assumes a 32-bit AHB-Lite register bus and a pixel stream from two pipes.
 */
package lvpc_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [31:0] LVPC_PORT_CTRL_ADDR = 32'h0006_1180;
    localparam logic [31:0] LVPC_SEQ_CTRL_ADDR = 32'h0006_1190;
    localparam logic [31:0] LVPC_SEQ_STAT_ADDR = 32'h0006_1194;
    localparam logic [31:0] LVPC_PORT_CTRL_RST = 32'h4000_0000;
    localparam logic [31:0] LVPC_PORT_CTRL_WMASK = 32'h43FF_87FC;
    localparam logic [31:0] LVPC_PORT_CTRL_EMASK = 32'h8000_0000;
    localparam logic [15:0] LVPC_UNLOCK_KEY = 16'hABCD;

    // ************************************************************
    // Field positions of the port control register
    // ************************************************************
    localparam int LVPC_B_EN = 31;
    localparam int LVPC_B_PIPE = 30;
    localparam int LVPC_B_DITH = 25;
    localparam int LVPC_B_FMT = 24;
    localparam int LVPC_B_HSUB = 23;
    localparam int LVPC_B_VSUB = 22;
    localparam int LVPC_B_VPOL = 21;
    localparam int LVPC_B_HPOL = 20;
    localparam int LVPC_B_DEINV = 19;
    localparam int LVPC_B_CH2_LO = 17;
    localparam int LVPC_B_FILL = 16;
    localparam int LVPC_B_BORDER = 15;
    localparam int LVPC_B_PDSTATE = 10;
    localparam int LVPC_B_CHA_LO = 8;
    localparam int LVPC_B_P3_LO = 6;
    localparam int LVPC_B_SECOND_LINK_CLOCK_PAIR_LO = 4;
    localparam int LVPC_B_CHB_LO = 2;

    // Lane activity codes
    localparam logic [1:0] LVPC_LANE_OFF = 2'h0;
    localparam logic [1:0] LVPC_LANE_ZERO = 2'h1;
    localparam logic [1:0] LVPC_LANE_RUN = 2'h3;

    // Second channel control codes
    localparam logic [1:0] LVPC_CH2_NORMAL = 2'h0;
    localparam logic [1:0] LVPC_CH2_ZEROS = 2'h2;
    localparam logic [1:0] LVPC_CH2_SUBST = 2'h3;

    // Sequencer status positions in the status register
    localparam int LVPC_S_PWR = 0;
    localparam int LVPC_S_PWRUP = 1;
    localparam int LVPC_S_READY = 2;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
        logic de;
        logic blank_n;
        logic hs;
        logic vs;
    } lvpc_pix_t;

    // Per-lane state: pwr=powered, act=data/clock running
    typedef struct packed {
        logic pwr;
        logic act;
    } lvpc_lane_t;

    typedef struct packed {
        logic [6:0] data;   // one 7-bit slot per pair
        logic pwr;
        logic drv;          // output enable of both lines
    } lvpc_pair_t;

endpackage

/* hdl/lvpc_port.sv */
/*
 * Panel port control: register, pixel source select, dither, control
 * mapping onto the link slots, and per-lane power/activity limits.
 * Assumes one AHB-Lite master, the panel sequencer state as inputs from
 * another clock domain, and pixel pipes on hclk.
 */
// Functional notes
// - Port enable zero keeps every pair powered down; one enables port.
// - Pipe assign bit: zero pipe A, one pipe B, reset is B.
// - Dither bit one dithers 8 to 6 bits; zero bypasses dither.
// - Format bit with lane fields selects .0 or 24.1 mapping.
// - Dual channel substitute mode sends first substitute bit as B hsync.
// - Dual channel substitute mode sends second substitute bit as B vsync.
// - Vsync polarity bit one inverts link vsync to active low.
// - Hsync polarity bit one inverts link hsync to active low.
// - Enable invert bit one makes the panel enable active low.
// - Second channel control: 00 normal, 10 zeros, 11 substitutes.
// - Fill bit chooses zero or duplicated data for reserved slots.
// - Border bit selects active enable or inverted blank as enable.
// - Sequencer power-down: drive zero or float per state bit.
// - Channel A field: 00 off, 01 data zero, 11 run.
// - Fourth pair field limits fourth pairs together with channel field.
// - Second clock field limits clock B, gated by channel B field.
// - Channel B field caps B lanes; software writes 00 or 11.
// - Sequencer power-down holds all lanes down regardless of fields.
// - Sequencer write protection leaves the register unchanged.
// - Protect while panel up or powering up, unless key unlocks.
// - Sequencer start needs port enabled, pipe and PLL ready.
`timescale 1ns/10ps
`default_nettype none
module lvpc_port
    import lvpc_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Panel sequencer state, asynchronous
    input wire logic seq_panel_on,
    input wire logic seq_powering_up,
    input wire logic pipe_pll_ready,
    output logic seq_port_ready,
    // Pixel pipes
    input wire lvpc_pix_t pipe_a,
    input wire lvpc_pix_t pipe_b,
    // Link pairs: A0..A3, B0..B3, clock A, clock B
    output lvpc_pair_t pair_a0,
    output lvpc_pair_t pair_a1,
    output lvpc_pair_t pair_a2,
    output lvpc_pair_t pair_a3,
    output lvpc_pair_t pair_b0,
    output lvpc_pair_t pair_b1,
    output lvpc_pair_t pair_b2,
    output lvpc_pair_t pair_b3,
    output lvpc_pair_t pair_first_link_clock_pair,
    output lvpc_pair_t pair_second_link_clock_pair
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [31:0] ctrl;
        logic [15:0] key;
        logic [1:0] on_s1;
        logic [1:0] on_s2;
        logic [1:0] up_s1;
        logic [1:0] up_s2;
        logic wr_pend;
        logic [1:0] wr_sel;
        logic [31:0] rdata;
        logic [1:0] frm;
        logic ready;
        lvpc_pair_t [9:0] pr;
    } lvpc_state_t;

    lvpc_state_t s_q;
    lvpc_state_t s_d;

    // Reserved codes fold to power-down, so 10 never runs a lane
    function automatic lvpc_lane_t lane_of(input logic [1:0] code);
        lvpc_lane_t l;
        l.pwr = (code == LVPC_LANE_ZERO) || (code == LVPC_LANE_RUN);
        l.act = (code == LVPC_LANE_RUN);
        return l;
    endfunction

    function automatic lvpc_lane_t lane_and(input lvpc_lane_t x,
                                            input lvpc_lane_t y);
        lvpc_lane_t l;
        l.pwr = x.pwr & y.pwr;
        l.act = x.act & y.act;
        return l;
    endfunction

    function automatic logic [5:0] dith6(input logic [7:0] c,
                                         input logic [1:0] ph);
        logic [8:0] t;
        t = {1'b0, c} + {7'h00, ph};
        return t[8] ? 6'h3F : t[7:2];
    endfunction

    // ************************************************************
    // Combinational next state
    // ************************************************************
    lvpc_pix_t px;
    logic protect;
    logic seq_down;
    logic addr_ok;
    logic [31:0] wval;
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
    logic de_l;
    logic hs_l;
    logic vs_l;
    logic de2;
    logic hs2;
    logic vs2;
    logic [1:0] ch2;
    lvpc_lane_t la;
    lvpc_lane_t lb;
    lvpc_lane_t l3;
    lvpc_lane_t lck;
    lvpc_lane_t [9:0] lane;
    logic [6:0] slot [0:7];
    logic fill;

    always_comb begin
        s_d = s_q;
        wval = 32'h0000_0000;
        if (clk_en) begin
            // Sequencer levels cross domains through two flops
            s_d.on_s1 = {seq_panel_on, seq_powering_up};
            s_d.on_s2 = s_q.on_s1;
        end
        seq_down = ~s_q.on_s2[1] & ~s_q.on_s2[0];
        protect = (s_q.on_s2[1] | s_q.on_s2[0])
                  && (s_q.key != LVPC_UNLOCK_KEY);
        px = s_q.ctrl[LVPC_B_PIPE] ? pipe_b : pipe_a;
        // Bus data phase
        if (clk_en && s_q.wr_pend) begin
            if (s_q.wr_sel == 2'h1 && !protect) begin
                wval = (hwdata & LVPC_PORT_CTRL_WMASK)
                       | (hwdata & LVPC_PORT_CTRL_EMASK)
                       | (s_q.ctrl & ~(LVPC_PORT_CTRL_WMASK
                                       | LVPC_PORT_CTRL_EMASK));
                s_d.ctrl = wval;
            end else if (s_q.wr_sel == 2'h2) begin
                s_d.key = hwdata[31:16];
            end
        end
        addr_ok = 1'b0;
        if (clk_en) begin
            s_d.wr_pend = 1'b0;
            if (hsel && hready && htrans[1]) begin
                if (haddr == LVPC_PORT_CTRL_ADDR) begin
                    s_d.wr_sel = 2'h1;
                    // Take the merged word so a read right after a write sees it
                    s_d.rdata = s_d.ctrl;
                    addr_ok = 1'b1;
                end else if (haddr == LVPC_SEQ_CTRL_ADDR) begin
                    s_d.wr_sel = 2'h2;
                    s_d.rdata = {s_d.key, 16'h0000};
                    addr_ok = 1'b1;
                end else if (haddr == LVPC_SEQ_STAT_ADDR) begin
                    s_d.wr_sel = 2'h0;
                    s_d.rdata = {29'h0, s_q.ready, s_q.on_s2[0],
                                 s_q.on_s2[1]};
                end else begin
                    s_d.wr_sel = 2'h0;
                    s_d.rdata = 32'h0000_0000;
                end
                s_d.wr_pend = hwrite & addr_ok;
            end
            s_d.ready = s_q.ctrl[LVPC_B_EN] & pipe_pll_ready;
            s_d.frm = s_q.frm + 2'h1;
        end
        // Colour path
        if (s_q.ctrl[LVPC_B_DITH]) begin
            r = {dith6(px.r, s_q.frm), 2'h0};
            g = {dith6(px.g, s_q.frm ^ 2'h1), 2'h0};
            b = {dith6(px.b, s_q.frm ^ 2'h2), 2'h0};
        end else begin
            r = px.r;
            g = px.g;
            b = px.b;
        end
        // Control indicators
        de_l = (s_q.ctrl[LVPC_B_BORDER] ? px.blank_n : px.de)
               ^ s_q.ctrl[LVPC_B_DEINV];
        hs_l = px.hs ^ s_q.ctrl[LVPC_B_HPOL];
        vs_l = px.vs ^ s_q.ctrl[LVPC_B_VPOL];
        ch2 = s_q.ctrl[LVPC_B_CH2_LO +: 2];
        if (ch2 == LVPC_CH2_NORMAL) begin
            de2 = de_l;
            hs2 = hs_l;
            vs2 = vs_l;
        end else if (ch2 == LVPC_CH2_SUBST) begin
            de2 = 1'b0;
            hs2 = s_q.ctrl[LVPC_B_HSUB];
            vs2 = s_q.ctrl[LVPC_B_VSUB];
        end else begin
            de2 = 1'b0;
            hs2 = 1'b0;
            vs2 = 1'b0;
        end
        fill = s_q.ctrl[LVPC_B_FILL] & r[0];
        // Format 0 puts the top six bits on pairs 0-2, format 1 the top two
        // bits on pair 3 with the low six on pairs 0-2
        if (s_q.ctrl[LVPC_B_FMT]) begin
            slot[0] = {g[0], r[5:0]};
            slot[1] = {b[1:0], g[5:1]};
            slot[2] = {de_l, vs_l, hs_l, b[5:2]};
            slot[3] = {fill, b[7:6], g[7:6], r[7:6]};
        end else begin
            slot[0] = {g[2], r[7:2]};
            slot[1] = {b[3:2], g[7:3]};
            slot[2] = {de_l, vs_l, hs_l, b[7:4]};
            slot[3] = {fill, b[1:0], g[1:0], r[1:0]};
        end
        slot[4] = slot[0];
        slot[5] = slot[1];
        slot[6] = {de2, vs2, hs2, slot[2][3:0]};
        slot[7] = slot[3];
        // Lane limits
        la = lane_of(s_q.ctrl[LVPC_B_CHA_LO +: 2]);
        lb = lane_of(s_q.ctrl[LVPC_B_CHB_LO +: 2]);
        l3 = lane_of(s_q.ctrl[LVPC_B_P3_LO +: 2]);
        lck = lane_and(lane_of(s_q.ctrl[LVPC_B_SECOND_LINK_CLOCK_PAIR_LO +: 2]), lb);
        for (int i = 0; i < 10; i++) begin
            if (i < 3) begin
                lane[i] = la;
            end else if (i == 3) begin
                lane[i] = lane_and(l3, la);
            end else if (i < 7) begin
                lane[i] = lb;
            end else if (i == 7) begin
                lane[i] = lane_and(l3, lb);
            end else if (i == 8) begin
                lane[i] = la;
            end else begin
                lane[i] = lck;
            end
            // Timing slot on pairs 2 and 6 stays live in data-zero mode
            if (seq_down || !s_q.ctrl[LVPC_B_EN]) begin
                lane[i] = '0;
            end
        end
        if (clk_en) begin
            for (int i = 0; i < 10; i++) begin
                s_d.pr[i].pwr = lane[i].pwr;
                // Down pairs drive zero or float by the state bit
                s_d.pr[i].drv = lane[i].pwr
                                | ~s_q.ctrl[LVPC_B_PDSTATE];
                // Clock A keeps running in data-zero mode, clock B does not
                if (i == 8) begin
                    s_d.pr[i].data = (lane[i].pwr) ? 7'h63 : 7'h00;
                end else if (i == 9) begin
                    s_d.pr[i].data = (lane[i].act) ? 7'h63 : 7'h00;
                end else if (lane[i].act) begin
                    s_d.pr[i].data = slot[i];
                end else if (lane[i].pwr && (i == 2 || i == 6)) begin
                    s_d.pr[i].data = {slot[i][6:4], 4'h0};
                end else begin
                    s_d.pr[i].data = 7'h00;
                end
            end
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
            s_q.ctrl <= LVPC_PORT_CTRL_RST;
            // Down pairs drive zero from the start, as the state bit resets 0
            s_q.pr <= {10{7'h00, 1'b0, 1'b1}};
        end else begin
            s_q <= s_d;
        end
    end

    assign hrdata = s_q.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign seq_port_ready = s_q.ready;
    assign pair_a0 = s_q.pr[0];
    assign pair_a1 = s_q.pr[1];
    assign pair_a2 = s_q.pr[2];
    assign pair_a3 = s_q.pr[3];
    assign pair_b0 = s_q.pr[4];
    assign pair_b1 = s_q.pr[5];
    assign pair_b2 = s_q.pr[6];
    assign pair_b3 = s_q.pr[7];
    assign pair_first_link_clock_pair = s_q.pr[8];
    assign pair_second_link_clock_pair = s_q.pr[9];

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_seq_down;
        clk_en && !s_q.on_s2[1] && !s_q.on_s2[0];
    endsequence

    property p_dis_down;
        clk_en && !s_q.ctrl[LVPC_B_EN] |=> !pair_a0.pwr && !pair_second_link_clock_pair.pwr;
    endproperty
    a_dis_down: assert property (p_dis_down) else $error("port off lane up");

    property p_seq_down;
        s_seq_down |=> !pair_a1.pwr && !pair_b1.pwr && !pair_first_link_clock_pair.pwr;
    endproperty
    a_seq_down: assert property (p_seq_down) else $error("seq down lane up");

    property p_float;
        s_seq_down ##0 s_q.ctrl[LVPC_B_PDSTATE] |=> !pair_a0.drv;
    endproperty
    a_float: assert property (p_float) else $error("pair driven");

    property p_protect;
        protect && s_q.wr_pend && s_q.wr_sel == 2'h1 |=> $stable(s_q.ctrl);
    endproperty
    a_protect: assert property (p_protect) else $error("protected write");

    property p_ready;
        clk_en && !s_q.ctrl[LVPC_B_EN] |=> !seq_port_ready;
    endproperty
    a_ready: assert property (p_ready) else $error("ready w/o port");

    property p_second_link_clock_pair;
        clk_en && s_q.ctrl[LVPC_B_CHB_LO +: 2] == LVPC_LANE_OFF
            |=> !pair_second_link_clock_pair.pwr;
    endproperty
    a_second_link_clock_pair: assert property (p_second_link_clock_pair) else $error("clock b up");

    property p_a3;
        clk_en && s_q.ctrl[LVPC_B_P3_LO +: 2] != LVPC_LANE_RUN
            |=> pair_a3.data == 7'h00;
    endproperty
    a_a3: assert property (p_a3) else $error("pair 3 data");

    property p_resv;
        clk_en && s_q.ctrl[LVPC_B_CHA_LO +: 2] == 2'h2 |=> !pair_a0.pwr;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved runs");

    property p_first_link_clock_pair;
        clk_en && s_q.ctrl[LVPC_B_EN] && !seq_down
            && s_q.ctrl[LVPC_B_CHA_LO +: 2] == LVPC_LANE_ZERO
            |=> pair_first_link_clock_pair.data == 7'h63;
    endproperty
    a_first_link_clock_pair: assert property (p_first_link_clock_pair) else $error("clock a stopped");

    property p_ch2zero;
        clk_en && s_q.ctrl[LVPC_B_CH2_LO +: 2] == LVPC_CH2_ZEROS
            |=> pair_b2.data[6:4] == 3'h0;
    endproperty
    a_ch2zero: assert property (p_ch2zero) else $error("b timing sent");

endmodule // lvpc_port
`default_nettype wire

/* dv/lvpc_panel.sv */
/*
 * Flat panel receiver model: reports per-pair power, drive and zero data.
 * Assumes the port's registered pair outputs, ordered a0..a3, b0..b3,
 * clock a, clock b.
 */
`timescale 1ns/10ps
`default_nettype none
module lvpc_panel
    import lvpc_pkg::*;
(
    // Link pairs
    input wire lvpc_pair_t [9:0] pairs,
    // Per-lane summary
    output logic [9:0] lane_pwr,
    output logic [9:0] lane_drv,
    output logic [9:0] lane_zero
);
    // A floating pair is never taken as a zero, so a missing drive shows up
    always_comb begin
        for (int i = 0; i < 10; i++) begin
            lane_pwr[i] = pairs[i].pwr;
            lane_drv[i] = pairs[i].drv;
            lane_zero[i] = pairs[i].drv && (pairs[i].data === 7'h00);
        end
    end
endmodule // lvpc_panel
`default_nettype wire

/* dv/lvpc_port_test.sv */
/*
 * Self-checking bench for the panel port control block.
 * Assumes a single AHB-Lite master, zero-wait slave and a panel model.
 */
`timescale 1ns/10ps
`default_nettype none
module lvpc_port_test;
    import lvpc_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic seq_on = 1'b0;
    logic seq_up = 1'b0;
    logic pll_rdy = 1'b0;
    lvpc_pix_t pix_a = 28'hA55AC3F;
    lvpc_pix_t pix_b = 28'h3C9669F;
    wire logic [31:0] hrdata;
    wire logic hreadyout;
    wire logic hresp;
    wire logic port_rdy;
    wire lvpc_pair_t [9:0] pairs;
    wire logic [9:0] l_pwr;
    wire logic [9:0] l_drv;
    wire logic [9:0] l_zero;
    logic [31:0] rd;
    logic [31:0] tbl [8];
    int n_fail = 0;
    int n_compared = 0;

    initial begin
        forever #5 hclk = ~hclk;
    end

    lvpc_port dut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .seq_panel_on(seq_on), .seq_powering_up(seq_up),
        .pipe_pll_ready(pll_rdy), .seq_port_ready(port_rdy),
        .pipe_a(pix_a), .pipe_b(pix_b),
        .pair_a0(pairs[0]), .pair_a1(pairs[1]), .pair_a2(pairs[2]),
        .pair_a3(pairs[3]), .pair_b0(pairs[4]), .pair_b1(pairs[5]),
        .pair_b2(pairs[6]), .pair_b3(pairs[7]), .pair_first_link_clock_pair(pairs[8]),
        .pair_second_link_clock_pair(pairs[9]));

    lvpc_panel panel (.pairs(pairs), .lane_pwr(l_pwr), .lane_drv(l_drv),
        .lane_zero(l_zero));

    // ************************************************************
    // Bus access and checks
    // ************************************************************
    task automatic bus(input logic wr, input logic [31:0] a, d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic chk32(input logic [31:0] g, e);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %0t word got %h exp %h", $time, g, e);
        end
    endtask

    task automatic chk10(input logic [9:0] g, e);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %0t lanes got %h exp %h", $time, g, e);
        end
    endtask

    // Sequencer levels pass a two-flop synchroniser before they count
    task automatic settle;
        repeat (8) @(posedge hclk);
    endtask

    // Powered lanes with the panel on: code bit 0 set means powered
    function automatic logic [9:0] exp_pwr(input logic [31:0] c);
        logic a;
        logic b;
        a = c[31] & c[8];
        b = c[31] & c[2];
        return {b & c[4], a, b & c[6], b, b, b, a & c[6], a, a, a};
    endfunction

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge hclk);
        n_fail++;
        test_done;
    end

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        tbl = '{32'h8000_03FC, 32'h8000_02FC, 32'h8000_033C, 32'h8000_03CC,
            32'h8000_03F0, 32'h8000_03F8, 32'h0000_03FC, 32'h8000_017C};
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, LVPC_PORT_CTRL_ADDR, 32'h0);
        chk32(rd, LVPC_PORT_CTRL_RST);
        chk10(l_pwr, 10'h000);
        chk10(l_drv & l_zero, 10'h3FF);
        $display("test reset done");

        // Unmapped place: write dropped, reads zero
        bus(1'b1, 32'h0006_1184, 32'hFFFF_FFFF);
        bus(1'b0, 32'h0006_1184, 32'h0);
        chk32(rd, 32'h0);
        $display("test unmapped done");

        // Sequencer down overrides every lane field
        for (int s = 0; s < 2; s++) begin
            bus(1'b1, LVPC_PORT_CTRL_ADDR, 32'h8000_03FC | (s << 10));
            settle;
            chk10(l_pwr, 10'h000);
            chk10(l_drv, s ? 10'h000 : 10'h3FF);
            chk10(l_zero | {10{s[0]}}, 10'h3FF);
        end
        chk10({9'h0, port_rdy}, 10'h000);
        pll_rdy <= 1'b1;
        settle;
        chk10({9'h0, port_rdy}, 10'h001);
        $display("test power down done");

        // Unlocked, panel on: lane limits from eight field settings in tbl
        bus(1'b1, LVPC_SEQ_CTRL_ADDR, {LVPC_UNLOCK_KEY, 16'h0000});
        seq_on <= 1'b1;
        settle;
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, LVPC_PORT_CTRL_ADDR, tbl[i]);
            settle;
            bus(1'b0, LVPC_PORT_CTRL_ADDR, 32'h0);
            chk32(rd, tbl[i]);
            chk10(l_pwr, exp_pwr(tbl[i]));
        end
        chk10(l_zero & 10'h088, 10'h088);
        chk10({3'h0, pairs[8].data}, 10'h063);
        chk10({9'h0, port_rdy}, 10'h001);
        $display("test lane limits done");

        // Pipe B, every indicator inverted, second channel substitutes
        bus(1'b1, LVPC_PORT_CTRL_ADDR, 32'hC0BE_03FC);
        settle;
        chk10({3'h0, pairs[2].data}, 10'h006);
        chk10({3'h0, pairs[6].data}, 10'h016);
        // Pipe A in the 24.1 layout: top two bits of each colour on pair 3
        bus(1'b1, LVPC_PORT_CTRL_ADDR, 32'h8100_03FC);
        settle;
        chk10({3'h0, pairs[3].data}, 10'h036);
        bus(1'b1, LVPC_PORT_CTRL_ADDR, 32'h8000_017C);
        settle;
        $display("test data mapping done");

        // Locked: writes while on or powering up leave the word unchanged
        bus(1'b1, LVPC_SEQ_CTRL_ADDR, 32'h0);
        settle;
        bus(1'b1, LVPC_PORT_CTRL_ADDR, 32'h8000_03FC);
        bus(1'b0, LVPC_PORT_CTRL_ADDR, 32'h0);
        chk32(rd, 32'h8000_017C);
        seq_on <= 1'b0;
        seq_up <= 1'b1;
        settle;
        bus(1'b1, LVPC_PORT_CTRL_ADDR, 32'h8000_03FC);
        bus(1'b0, LVPC_PORT_CTRL_ADDR, 32'h0);
        chk32(rd, 32'h8000_017C);
        seq_up <= 1'b0;
        settle;
        bus(1'b1, LVPC_PORT_CTRL_ADDR, 32'h4000_0000);
        bus(1'b0, LVPC_PORT_CTRL_ADDR, 32'h0);
        chk32(rd, 32'h4000_0000);
        settle;
        chk10({9'h0, port_rdy}, 10'h000);
        $display("test write protect done");
        test_done;
    end
endmodule // lvpc_port_test
`default_nettype wire
